// file: rtl/bra_pkg.sv
// constants for the two-port register array
package bra_pkg;
  localparam int NUM_REGS = 16;
  localparam logic [3:0] FLAG_LO_IDX = 4'h0;
  localparam logic [3:0] FLAG_HI_IDX = 4'h1;
  localparam logic [3:0] PROT_LO_IDX = 4'hE;
  localparam logic [3:0] PROT_HI_IDX = 4'hF;
  localparam int PROT_LO_BIT = 0;
  localparam int PROT_HI_BIT = 1;
  localparam logic [2:0] DMA_PAIR_LO = 3'h6;
  localparam logic [2:0] DMA_PAIR_HI = 3'h7;
  localparam logic [3:0] SEC_ADDR_BASE = 4'h3;
  localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage

// file: rtl/bra_top.sv
// two-port sixteen-byte register array with flag handshake
`timescale 1ns/1ps
// Behaviour
// - one shared sixteen-byte store reached by host and controller ports
// - host reads or writes any location, byte or word wide
// - controller selects a register in one cycle, transfers data later
// - both data ports are bidirectional with three-state drivers
// - low dma enable puts host port in dma mode only
// - host data is two byte lanes, lane a bit 0 most significant
// - controller port answers select and write only with bank enabled
// - select with clock high treats bus value as address, selects match
// - selection holds until a new address arrives on the same bank
// - write command with clock high stores bus value in selected register
// - secondary bus is eight active-low lines, line 0 most significant
// - host write strobe stores host data when in write mode
// - low programmed io enable selects register by four address inputs
// - host address bit 3 most significant, bit 0 least significant
// - byte/word high gives byte mode, low gives word mode
// - write-protect logic blocks host writes in byte and word mode
// - two protect flag bits guard the top two registers, host read-only
// - writing a general register sets its flag; software clears it
// - byte mode: address bit 0 picks even lane a or odd lane b
// - dma mode ignores address bits 1 to 3, bit 0 picks location
module bra_top (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic DMA_ENABLE_N,
  input wire logic PROG_IO_ENABLE_N,
  input wire logic [3:0] HOST_ADDR,
  input wire logic BYTE_MODE,
  input wire logic HOST_READ,
  input wire logic HOST_WRITE_STROBE,
  input wire logic [7:0] HOST_DATA_LANE_A_IN,
  output logic [7:0] HOST_DATA_LANE_A_OUT,
  output logic HOST_DATA_LANE_A_OE_N,
  input wire logic [7:0] HOST_DATA_LANE_B_IN,
  output logic [7:0] HOST_DATA_LANE_B_OUT,
  output logic HOST_DATA_LANE_B_OE_N,
  input wire logic BANK_ENABLE_N,
  input wire logic MASTER_CLK,
  input wire logic SELECT_CMD,
  input wire logic WRITE_CMD,
  input wire logic SEC_READ,
  input wire logic [7:0] SEC_BUS_N_IN,
  output logic [7:0] SEC_BUS_N_OUT,
  output logic SEC_BUS_N_OE_N,
  output logic SEC_SELECTED
);
  logic [7:0] mem_ff [bra_pkg::NUM_REGS];
  logic [7:0] nxt_mem [bra_pkg::NUM_REGS];
  logic [3:0] sel_idx_ff;
  logic sel_valid_ff;
  logic [7:0] lane_a_ff;
  logic [7:0] lane_b_ff;
  logic [7:0] sec_out_ff;

  // port modes
  wire dma_mode = !DMA_ENABLE_N;
  wire pio_mode = !PROG_IO_ENABLE_N && DMA_ENABLE_N;
  wire host_on = dma_mode || pio_mode;
  // dma fixes the pair high bits, only bit 0 steers
  wire [2:0] pair_idx = dma_mode ?
    (HOST_ADDR[0] ? bra_pkg::DMA_PAIR_HI : bra_pkg::DMA_PAIR_LO) :
    HOST_ADDR[3:1];
  // in dma byte mode the odd/even choice stays inside pair 7
  wire [2:0] byte_pair = dma_mode ? bra_pkg::DMA_PAIR_HI : HOST_ADDR[3:1];
  wire odd_sel = HOST_ADDR[0];
  wire [2:0] eff_pair = BYTE_MODE ? byte_pair : pair_idx;
  wire [3:0] even_idx = {eff_pair, 1'b0};
  wire [3:0] odd_idx = {eff_pair, 1'b1};
  wire use_a = host_on && (!BYTE_MODE || !odd_sel);
  wire use_b = host_on && (!BYTE_MODE || odd_sel);
  wire host_wr = host_on && !HOST_READ && HOST_WRITE_STROBE;
  wire [7:0] flag_lo = mem_ff[bra_pkg::FLAG_LO_IDX];
  // protect bits live in the low flag register
  wire prot_a = (even_idx == bra_pkg::PROT_LO_IDX) &&
    flag_lo[bra_pkg::PROT_LO_BIT];
  wire prot_b = (odd_idx == bra_pkg::PROT_HI_IDX) &&
    flag_lo[bra_pkg::PROT_HI_BIT];
  wire host_wr_a = host_wr && use_a && !prot_a;
  wire host_wr_b = host_wr && use_b && !prot_b;
  // in byte mode the host ties lanes, so odd data arrives on lane b
  wire [7:0] host_byte_a = HOST_DATA_LANE_A_IN;
  wire [7:0] host_byte_b = HOST_DATA_LANE_B_IN;

  // secondary port; bus is active low
  wire sec_cycle = !BANK_ENABLE_N && MASTER_CLK;
  wire sec_sel = sec_cycle && SELECT_CMD && !WRITE_CMD;
  wire sec_wr = sec_cycle && WRITE_CMD && !SELECT_CMD && sel_valid_ff;
  wire [7:0] sec_val = ~SEC_BUS_N_IN;
  wire addr_hit = (sec_val[7:4] == bra_pkg::SEC_ADDR_BASE);

  // flag bit for register i: i>=2 maps to bit (i) across the two flags
  always_comb
  begin
    for (int i = 0; i < bra_pkg::NUM_REGS; i++)
    begin
      nxt_mem[i] = mem_ff[i];
    end
    // host writes first so the controller write below overrides
    if (host_wr_a)
    begin
      nxt_mem[even_idx] = host_byte_a;
    end
    if (host_wr_b)
    begin
      nxt_mem[odd_idx] = host_byte_b;
    end
    if (host_wr_a && even_idx == bra_pkg::FLAG_LO_IDX)
    begin
      // host cannot change protect bits
      nxt_mem[bra_pkg::FLAG_LO_IDX][1:0] = flag_lo[1:0];
    end
    if (sec_wr)
    begin
      nxt_mem[sel_idx_ff] = sec_val;
    end
    // write-set flags are applied last so a set beats a clear
    for (int i = 2; i < bra_pkg::NUM_REGS; i++)
    begin
      if ((host_wr_a && even_idx == i[3:0]) ||
          (host_wr_b && odd_idx == i[3:0]) ||
          (sec_wr && sel_idx_ff == i[3:0]))
      begin
        nxt_mem[i[3:0] >> 3][i[2:0]] = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < bra_pkg::NUM_REGS; i++)
      begin
        mem_ff[i] <= bra_pkg::DATA_ZERO;
      end
    end
    else
    begin
      mem_ff <= nxt_mem;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      sel_valid_ff <= 1'b0;
      sel_idx_ff <= 4'h0;
    end
    else if (sec_sel)
    begin
      // any new address deselects; a match reselects
      sel_valid_ff <= addr_hit;
      sel_idx_ff <= sec_val[3:0];
    end
  end

  // read data registered one cycle behind the address
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      lane_a_ff <= bra_pkg::DATA_ZERO;
      lane_b_ff <= bra_pkg::DATA_ZERO;
      sec_out_ff <= bra_pkg::DATA_ZERO;
    end
    else
    begin
      lane_a_ff <= mem_ff[even_idx];
      lane_b_ff <= mem_ff[odd_idx];
      sec_out_ff <= ~mem_ff[sel_idx_ff];
    end
  end

  assign HOST_DATA_LANE_A_OUT = lane_a_ff;
  assign HOST_DATA_LANE_B_OUT = lane_b_ff;
  assign HOST_DATA_LANE_A_OE_N = !(use_a && HOST_READ);
  assign HOST_DATA_LANE_B_OE_N = !(use_b && HOST_READ);
  assign SEC_BUS_N_OUT = sec_out_ff;
  // drive only when selected, enabled and no command in flight
  assign SEC_BUS_N_OE_N = !(!BANK_ENABLE_N && sel_valid_ff && SEC_READ &&
    !SELECT_CMD && !WRITE_CMD);
  assign SEC_SELECTED = sel_valid_ff;
endmodule

// file: verification/bra_chk_sva.sv
// port assertions for the register array
`timescale 1ns/1ps
module bra_chk (
  input wire logic CORE_CLK, SYS_RST, DMA_ENABLE_N, PROG_IO_ENABLE_N,
  input wire logic BYTE_MODE, HOST_READ, HOST_DATA_LANE_A_OE_N,
  input wire logic HOST_DATA_LANE_B_OE_N, BANK_ENABLE_N, MASTER_CLK,
  input wire logic SELECT_CMD, WRITE_CMD, SEC_READ, SEC_BUS_N_OE_N,
  input wire logic SEC_SELECTED,
  input wire logic [3:0] HOST_ADDR,
  input wire logic [7:0] SEC_BUS_N_IN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  wire oa = HOST_DATA_LANE_A_OE_N;
  wire ob = HOST_DATA_LANE_B_OE_N;
  wire rd = !PROG_IO_ENABLE_N && DMA_ENABLE_N && HOST_READ;
  wire by = rd && BYTE_MODE;
  wire sel = !BANK_ENABLE_N && MASTER_CLK && SELECT_CMD && !WRITE_CMD;
  // window 0x30 to 0x3F arrives inverted
  wire hit = SEC_BUS_N_IN[7:4] == 4'hC;
  chk_even_lane: assert property (
    by && !HOST_ADDR[0] |-> !oa && ob) else $error("even lane");
  chk_odd_lane: assert property (
    by && HOST_ADDR[0] |-> oa && !ob) else $error("odd lane");
  chk_word_lanes: assert property (
    rd && !BYTE_MODE |-> !oa && !ob) else $error("word lanes");
  chk_write_quiet: assert property (
    !HOST_READ && !PROG_IO_ENABLE_N |-> oa && ob) else $error("host drv");
  chk_sel_hit: assert property (
    sel && hit |=> SEC_SELECTED) else $error("select hit");
  chk_sel_miss: assert property (
    sel && !hit |=> !SEC_SELECTED) else $error("select miss");
  chk_sel_hold: assert property (
    !sel |=> $stable(SEC_SELECTED)) else $error("select hold");
  chk_sec_quiet: assert property (
    !SEC_SELECTED || !SEC_READ |-> SEC_BUS_N_OE_N) else $error("sec drv");
endmodule

// file: verification/bra_ctl_model.sv
// controller-side model of the secondary port
`timescale 1ns/1ps
module bra_ctl_model (
  input wire logic clk,
  input wire logic [7:0] bus_in_n,
  output logic bank_n, mclk, sel, wr, rd,
  output logic [7:0] bus_n
);
  initial {bank_n, mclk, sel, wr, rd, bus_n} = 13'h10FF;
  // address and data go out in separate cycles, inverted
  task cmd(input logic s, input logic [7:0] v);
    @(posedge clk);
    {bank_n, mclk, sel, wr} <= {2'h1, s, !s};
    bus_n <= ~v;
    @(posedge clk);
    {bank_n, mclk, sel, wr} <= 4'h8;
    // released bus shows the inverse of the last level
    bus_n <= v;
  endtask
  task get(output logic [7:0] d);
    @(posedge clk);
    {bank_n, rd} <= 2'h1;
    repeat (2) @(posedge clk);
    d = ~bus_in_n;
    {bank_n, rd} <= 2'h2;
  endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the register array
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0, rst = 1'h1, dn = 1'h1, bm = 1'h1, rdh = 1'h1, stb = 1'h0;
  logic pe = 1'h0;
  logic [3:0] ad = 4'h0;
  logic [7:0] da = 8'h00, db = 8'h00, oa, ob, sbo, sb, v;
  logic oea, oeb, soe, ssel, be_n, mck, scmd, wcmd, srd;
  int num_errors = 0, total_checks = 0;
  always #10 clk = ~clk;
  bra_top uut (.CORE_CLK(clk), .SYS_RST(rst), .DMA_ENABLE_N(dn),
    .PROG_IO_ENABLE_N(pe), .HOST_ADDR(ad), .BYTE_MODE(bm), .HOST_READ(rdh),
    .HOST_WRITE_STROBE(stb), .HOST_DATA_LANE_A_IN(da),
    .HOST_DATA_LANE_A_OUT(oa), .HOST_DATA_LANE_A_OE_N(oea),
    .HOST_DATA_LANE_B_IN(db), .HOST_DATA_LANE_B_OUT(ob),
    .HOST_DATA_LANE_B_OE_N(oeb), .BANK_ENABLE_N(be_n), .MASTER_CLK(mck),
    .SELECT_CMD(scmd), .WRITE_CMD(wcmd), .SEC_READ(srd),
    .SEC_BUS_N_IN(soe ? sb : sbo), .SEC_BUS_N_OUT(sbo),
    .SEC_BUS_N_OE_N(soe), .SEC_SELECTED(ssel));
  bra_ctl_model ctl (.clk(clk), .bus_in_n(sbo), .bank_n(be_n), .mclk(mck),
    .sel(scmd), .wr(wcmd), .rd(srd), .bus_n(sb));
  task chk(input string n, input logic [7:0] e, g);
    // look away from the launching edge so registered data has settled
    @(negedge clk);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // write holds the strobe one cycle; read waits for registered data
  task host(input logic w, d, b, input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    {dn, bm, ad, da, db, rdh, stb} <= {d, b, a, x, !w, w};
    repeat (2 - w) @(posedge clk);
    {rdh, stb} <= 2'h2;
  endtask
  task t_host;
    host(1'h1, 1'h1, 1'h1, 4'h5, 16'hFF5A);
    host(1'h1, 1'h1, 1'h1, 4'h4, 16'hA500);
    host(1'h0, 1'h1, 1'h1, 4'h5, 16'h0);
    chk("reg5", 8'h5A, ob);
    host(1'h0, 1'h1, 1'h1, 4'h4, 16'h0);
    chk("reg4", 8'hA5, oa);
    host(1'h1, 1'h1, 1'h0, 4'h9, 16'h1234);
    host(1'h0, 1'h1, 1'h0, 4'h8, 16'h0);
    chk("word a", 8'h12, oa);
    chk("word b", 8'h34, ob);
  endtask
  task t_sec;
    ctl.cmd(1'h1, 8'h33);
    ctl.cmd(1'h0, 8'hC3);
    host(1'h0, 1'h1, 1'h1, 4'h3, 16'h0);
    chk("sec write", 8'hC3, ob);
    host(1'h0, 1'h1, 1'h0, 4'h0, 16'h0);
    chk("flag lo", 8'h38, oa);
    chk("flag hi", 8'h03, ob);
    fork
      host(1'h1, 1'h1, 1'h1, 4'h3, 16'h0011);
      ctl.cmd(1'h0, 8'h99);
    join
    host(1'h0, 1'h1, 1'h1, 4'h3, 16'h0);
    chk("collision", 8'h99, ob);
    ctl.cmd(1'h1, 8'h34);
    ctl.get(v);
    chk("shared", 8'hA5, v);
    ctl.cmd(1'h1, 8'h45);
    ctl.cmd(1'h0, 8'h00);
    host(1'h0, 1'h1, 1'h1, 4'h5, 16'h0);
    chk("deselect", 8'h5A, ob);
  endtask
  task t_dma;
    host(1'h1, 1'h0, 1'h1, 4'h1, 16'h0077);
    host(1'h0, 1'h1, 1'h1, 4'hF, 16'h0);
    chk("dma byte", 8'h77, ob);
    ctl.cmd(1'h1, 8'h30);
    ctl.cmd(1'h0, 8'h02);
    host(1'h1, 1'h0, 1'h1, 4'h1, 16'h0088);
    host(1'h0, 1'h0, 1'h1, 4'h1, 16'h0);
    chk("protect", 8'h77, ob);
    @(posedge clk);
    {pe, dn, rdh} <= 3'h7;
    @(posedge clk);
    chk("idle lanes", 8'h03, {6'h00, oea, oeb});
  endtask
  task close_out;
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    t_host;
    t_sec;
    t_dma;
    close_out;
  end
endmodule
bind bra_top bra_chk chk (.*);
